// ### core/sdc_stall_ctrl.sv
// stall detection control: thresholds, sample timing, arming, flags
`timescale 1ns/1ps
`default_nettype none
module sdc_stall_ctrl
    import sdc_pkg::*;
#(
    parameter int POS_W = SDC_POS_W
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [3:0] nv_absolute_level_setting,
    input wire logic [3:0] nv_delta_level_setting,
    input wire logic set_detection_params_cmd,
    input wire logic program_nonvolatile_cmd,
    input wire logic [3:0] cmd_absolute_level_setting,
    input wire logic [3:0] cmd_delta_level_setting,
    input wire logic [2:0] cmd_sample_delay_select,
    input wire logic [2:0] cmd_activation_delay_steps,
    input wire logic cmd_full_duty_detect_enable,
    output logic nv_write_strobe,
    output logic [3:0] nv_write_absolute,
    output logic [3:0] nv_write_delta,
    input wire logic full_status_request,
    input wire logic short_status_request,
    input wire logic qualification_mode_cmd,
    input wire logic zero_cross_pin,
    input wire logic ramp_active_pin,
    input wire logic at_max_velocity_pin,
    input wire logic full_step_pin,
    input wire logic full_duty_pin,
    input wire logic positioning,
    input wire logic cmp_delta_low_pin,
    input wire logic cmp_delta_high_pin,
    input wire logic cmp_absolute_low_pin,
    input wire logic [POS_W-1:0] internal_position,
    input wire logic switch_input_pin,
    output logic [3:0] absolute_level_setting,
    output logic [3:0] delta_level_setting,
    output logic detection_enabled,
    output logic sample_strobe,
    output logic hard_stop,
    output logic [POS_W-1:0] current_position,
    output logic status_step_loss,
    output logic status_stall,
    output logic status_absolute_low,
    output logic status_delta_low,
    output logic status_delta_high,
    output logic qualification_mode,
    output logic switch_pin_analog_en,
    output logic switch_state
);
    // two-flop synchronisers for analog-side pins
    localparam int NSYNC = 8;
    logic [NSYNC-1:0] async_in;
    logic [NSYNC-1:0] sync1_q;
    logic [NSYNC-1:0] sync2_q;
    assign async_in = {zero_cross_pin, ramp_active_pin, at_max_velocity_pin, full_step_pin,
                       full_duty_pin, cmp_delta_low_pin, cmp_delta_high_pin, cmp_absolute_low_pin};
    genvar gi;
    generate
        for (gi = 0; gi < NSYNC; gi = gi + 1) begin : g_sync
            always_ff @(posedge sys_clk) begin
                if (rst) begin
                    sync1_q[gi] <= 1'b0;
                    sync2_q[gi] <= 1'b0;
                end else begin
                    sync1_q[gi] <= async_in[gi];
                    sync2_q[gi] <= sync1_q[gi];
                end
            end
        end
    endgenerate
    logic zc_s, ramp_s, vmax_s, fstep_s, fduty_s, dlo_s, dhi_s, alo_s;
    assign {zc_s, ramp_s, vmax_s, fstep_s, fduty_s, dlo_s, dhi_s, alo_s} = sync2_q;
    logic sw_sync1_q, sw_sync2_q;
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            sw_sync1_q <= 1'b0;
            sw_sync2_q <= 1'b0;
        end else begin
            sw_sync1_q <= switch_input_pin;
            sw_sync2_q <= sw_sync1_q;
        end
    end
    // edge detection on synchronised levels
    logic zc_prev_q, fstep_prev_q;
    wire zc_rise = zc_s & ~zc_prev_q;
    wire fstep_rise = fstep_s & ~fstep_prev_q;
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            zc_prev_q <= 1'b0;
            fstep_prev_q <= 1'b0;
        end else begin
            zc_prev_q <= zc_s;
            fstep_prev_q <= fstep_s;
        end
    end
    // working settings; nonvolatile copy is caught one cycle after reset release
    logic [3:0] abs_q, del_q;
    logic [2:0] sel_q, act_q;
    logic fden_q, loaded_q;
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            abs_q <= SDC_ABS_RST;
            del_q <= SDC_DEL_RST;
            sel_q <= 3'h0;
            act_q <= 3'h0;
            fden_q <= 1'b0;
            loaded_q <= 1'b0;
        end else if (!loaded_q) begin
            abs_q <= nv_absolute_level_setting;
            del_q <= nv_delta_level_setting;
            loaded_q <= 1'b1;
        end else if (set_detection_params_cmd) begin
            abs_q <= cmd_absolute_level_setting;
            del_q <= cmd_delta_level_setting;
            sel_q <= cmd_sample_delay_select;
            act_q <= cmd_activation_delay_steps;
            fden_q <= cmd_full_duty_detect_enable;
        end
    end
    assign absolute_level_setting = abs_q;
    assign delta_level_setting = del_q;
    logic nv_stb_q;
    logic [3:0] nv_abs_q, nv_del_q;
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            nv_stb_q <= 1'b0;
            nv_abs_q <= 4'h0;
            nv_del_q <= 4'h0;
        end else begin
            nv_stb_q <= program_nonvolatile_cmd;
            if (program_nonvolatile_cmd) begin
                nv_abs_q <= cmd_absolute_level_setting;
                nv_del_q <= cmd_delta_level_setting;
            end
        end
    end
    assign nv_write_strobe = nv_stb_q;
    assign nv_write_absolute = nv_abs_q;
    assign nv_write_delta = nv_del_q;
    wire det_en = (abs_q != SDC_THR_DISABLED) || (del_q != SDC_THR_DISABLED);
    assign detection_enabled = det_en;
    logic [SDC_DLY_W-1:0] dly_cyc;
    always_comb begin
        case (sel_q)
            3'h0: dly_cyc = SDC_DLY_CYC0;
            3'h1: dly_cyc = SDC_DLY_CYC1;
            3'h2: dly_cyc = SDC_DLY_CYC2;
            3'h3: dly_cyc = SDC_DLY_CYC3;
            3'h4: dly_cyc = SDC_DLY_CYC4;
            3'h5: dly_cyc = SDC_DLY_CYC5;
            3'h6: dly_cyc = SDC_DLY_CYC6;
            default: dly_cyc = SDC_DLY_CYC7;
        endcase
    end
    sdc_timer_t tstate_q;
    logic [SDC_DLY_W-1:0] tcnt_q;
    logic samp_q;
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            tstate_q <= SDC_T_IDLE;
            tcnt_q <= 16'h0000;
            samp_q <= 1'b0;
        end else begin
            samp_q <= 1'b0;
            case (tstate_q)
                SDC_T_IDLE: begin
                    if (zc_rise) begin
                        tcnt_q <= 16'h0001;
                        tstate_q <= SDC_T_RUN;
                    end
                end
                SDC_T_RUN: begin
                    if (tcnt_q >= dly_cyc) begin
                        samp_q <= 1'b1;
                        tstate_q <= SDC_T_IDLE;
                    end else begin
                        tcnt_q <= tcnt_q + 16'h0001;
                    end
                end
                default: tstate_q <= SDC_T_IDLE;
            endcase
        end
    end
    assign sample_strobe = samp_q;
    // arming after ramp plus full steps, at max velocity only
    sdc_phase_t phase_q;
    logic [2:0] steps_q;
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            phase_q <= SDC_IDLE;
            steps_q <= 3'h0;
        end else begin
            case (phase_q)
                SDC_IDLE: begin
                    if (ramp_s) begin
                        phase_q <= SDC_RAMP;
                    end
                end
                SDC_RAMP: begin
                    if (!ramp_s && vmax_s) begin
                        steps_q <= 3'h0;
                        phase_q <= (act_q == 3'h0) ? SDC_ARMED : SDC_WAIT;
                    end else if (!ramp_s) begin
                        phase_q <= SDC_IDLE;
                    end
                end
                SDC_WAIT: begin
                    if (!vmax_s) begin
                        phase_q <= SDC_IDLE;
                    end else if (fstep_rise) begin
                        if (steps_q + 3'h1 == act_q) begin
                            phase_q <= SDC_ARMED;
                        end
                        steps_q <= steps_q + 3'h1;
                    end
                end
                SDC_ARMED: begin
                    if (!vmax_s) begin
                        phase_q <= ramp_s ? SDC_RAMP : SDC_IDLE;
                    end
                end
                default: phase_q <= SDC_IDLE;
            endcase
        end
    end
    wire duty_ok = ~fduty_s | fden_q;
    wire eval = det_en & (phase_q == SDC_ARMED) & vmax_s & duty_ok & samp_q;
    wire set_dlo = eval & (del_q != SDC_THR_DISABLED) & dlo_s;
    wire set_dhi = eval & (del_q != SDC_THR_DISABLED) & dhi_s;
    wire set_alo = eval & (abs_q != SDC_THR_DISABLED) & alo_s;
    wire stall_evt = set_dlo | set_dhi | set_alo;
    wire stop_evt = stall_evt & positioning;
    wire clr_all = full_status_request;
    wire clr_loss = full_status_request | short_status_request;
    logic dlo_q, dhi_q, alo_q, loss_q, hs_q;
    logic [POS_W-1:0] pos_q;
    // sticky flags, set wins over clear
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            dlo_q <= 1'b0;
            dhi_q <= 1'b0;
            alo_q <= 1'b0;
            loss_q <= 1'b0;
        end else begin
            dlo_q <= set_dlo | (dlo_q & ~clr_all);
            dhi_q <= set_dhi | (dhi_q & ~clr_all);
            alo_q <= set_alo | (alo_q & ~clr_all);
            loss_q <= stop_evt | (loss_q & ~clr_loss);
        end
    end
    // position tracks internal counter every cycle, also on hard stop; hard stop is the stop event registered
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            hs_q <= 1'b0;
            pos_q <= '0;
        end else begin
            hs_q <= stop_evt;
            pos_q <= internal_position;
        end
    end
    assign hard_stop = hs_q;
    assign current_position = pos_q;
    assign status_step_loss = loss_q;
    assign status_stall = dlo_q | dhi_q | alo_q;
    assign status_absolute_low = alo_q;
    assign status_delta_low = dlo_q;
    assign status_delta_high = dhi_q;
    // qualification mode latch, only reset leaves
    logic qual_q;
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            qual_q <= 1'b0;
        end else if (qualification_mode_cmd) begin
            qual_q <= 1'b1;
        end
    end
    assign qualification_mode = qual_q;
    assign switch_pin_analog_en = qual_q;
    logic sw_q;
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            sw_q <= 1'b0;
        end else if (!qual_q) begin
            sw_q <= sw_sync2_q;
        end
    end
    assign switch_state = sw_q;
endmodule
`default_nettype wire

// ### shared/sdc_pkg.sv
// package of constants and types for the stall detection control block
package sdc_pkg;
    localparam int SDC_CLK_MHZ = 125;
    localparam int SDC_THR_W = 4;
    localparam int SDC_SEL_W = 3;
    localparam int SDC_POS_W = 16;
    localparam logic [3:0] SDC_THR_DISABLED = 4'h0;
    localparam logic [3:0] SDC_ABS_RST = 4'h0;
    localparam logic [3:0] SDC_DEL_RST = 4'h0;
    // sample delays in microseconds, codes 0 to 7
    localparam int SDC_DLY_US0 = 87;
    localparam int SDC_DLY_US1 = 130;
    localparam int SDC_DLY_US2 = 174;
    localparam int SDC_DLY_US3 = 217;
    localparam int SDC_DLY_US4 = 261;
    localparam int SDC_DLY_US5 = 304;
    localparam int SDC_DLY_US6 = 348;
    localparam int SDC_DLY_US7 = 391;
    localparam int SDC_DLY_W = 16;
    // least delays: whole microseconds give exact cycle counts
    localparam logic [15:0] SDC_DLY_CYC0 = 16'(SDC_DLY_US0 * SDC_CLK_MHZ);
    localparam logic [15:0] SDC_DLY_CYC1 = 16'(SDC_DLY_US1 * SDC_CLK_MHZ);
    localparam logic [15:0] SDC_DLY_CYC2 = 16'(SDC_DLY_US2 * SDC_CLK_MHZ);
    localparam logic [15:0] SDC_DLY_CYC3 = 16'(SDC_DLY_US3 * SDC_CLK_MHZ);
    localparam logic [15:0] SDC_DLY_CYC4 = 16'(SDC_DLY_US4 * SDC_CLK_MHZ);
    localparam logic [15:0] SDC_DLY_CYC5 = 16'(SDC_DLY_US5 * SDC_CLK_MHZ);
    localparam logic [15:0] SDC_DLY_CYC6 = 16'(SDC_DLY_US6 * SDC_CLK_MHZ);
    localparam logic [15:0] SDC_DLY_CYC7 = 16'(SDC_DLY_US7 * SDC_CLK_MHZ);
    // motion phase states
    typedef enum logic [3:0] {
        SDC_IDLE = 4'b0001,
        SDC_RAMP = 4'b0010,
        SDC_WAIT = 4'b0100,
        SDC_ARMED = 4'b1000
    } sdc_phase_t;
    // sample timer states
    typedef enum logic [1:0] {
        SDC_T_IDLE = 2'b01,
        SDC_T_RUN = 2'b10
    } sdc_timer_t;
endpackage

// ### dv/sdc_stall_ctrl_chk.sv
// port-level assertion checker for the stall detection control block
`timescale 1ns/1ps
`default_nettype none
module sdc_stall_ctrl_chk (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic program_nonvolatile_cmd,
    input wire logic [3:0] cmd_absolute_level_setting,
    input wire logic full_status_request,
    input wire logic short_status_request,
    input wire logic nv_write_strobe,
    input wire logic [3:0] nv_write_absolute,
    input wire logic [3:0] absolute_level_setting,
    input wire logic [3:0] delta_level_setting,
    input wire logic detection_enabled,
    input wire logic sample_strobe,
    input wire logic status_step_loss,
    input wire logic status_stall,
    input wire logic status_absolute_low,
    input wire logic status_delta_low,
    input wire logic status_delta_high,
    input wire logic qualification_mode,
    input wire logic switch_pin_analog_en,
    input wire logic switch_state
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    property p_stall_or;
        status_stall == (status_delta_low | status_delta_high | status_absolute_low);
    endproperty
    a_stall_or: assert property (p_stall_or) else $error("stall flag differs from its sources");
    property p_det_en;
        detection_enabled == (absolute_level_setting != 4'h0 || delta_level_setting != 4'h0);
    endproperty
    a_det_en: assert property (p_det_en) else $error("detection enable wrong");
    // a strobe in the request cycle may set again, and a set wins
    property p_full_clr;
        full_status_request && !sample_strobe |=> !status_stall && !status_step_loss;
    endproperty
    a_full_clr: assert property (p_full_clr) else $error("full status left flags set");
    property p_short;
        short_status_request && !full_status_request && !sample_strobe && status_stall
            |=> status_stall && !status_step_loss;
    endproperty
    a_short: assert property (p_short) else $error("short status cleared wrong flags");
    property p_sticky;
        status_delta_low && !full_status_request |=> status_delta_low;
    endproperty
    a_sticky: assert property (p_sticky) else $error("delta low flag dropped");
    property p_nv_wr;
        program_nonvolatile_cmd |=> nv_write_strobe && nv_write_absolute == $past(cmd_absolute_level_setting);
    endproperty
    a_nv_wr: assert property (p_nv_wr) else $error("nonvolatile write missing");
    property p_strobe;
        sample_strobe |=> !sample_strobe [*8];
    endproperty
    a_strobe: assert property (p_strobe) else $error("sample strobe repeated");
    property p_qual_hold;
        qualification_mode |=> qualification_mode;
    endproperty
    a_qual_hold: assert property (p_qual_hold) else $error("qualification mode left");
    property p_qual_pin;
        qualification_mode |=> switch_pin_analog_en && $stable(switch_state);
    endproperty
    a_qual_pin: assert property (p_qual_pin) else $error("switch pin not handed over");
endmodule
bind sdc_stall_ctrl sdc_stall_ctrl_chk chk (.*);
`default_nettype wire

// ### dv/sdc_master_model.sv
// bus master model issuing parameter and status commands
`timescale 1ns/1ps
`default_nettype none
module sdc_master_model (
    input wire logic sys_clk,
    output logic set_detection_params_cmd,
    output logic program_nonvolatile_cmd,
    output logic [3:0] cmd_absolute_level_setting,
    output logic [3:0] cmd_delta_level_setting,
    output logic [2:0] cmd_sample_delay_select,
    output logic [2:0] cmd_activation_delay_steps,
    output logic cmd_full_duty_detect_enable,
    output logic full_status_request,
    output logic short_status_request,
    output logic qualification_mode_cmd
);
    initial begin
        {set_detection_params_cmd, program_nonvolatile_cmd, full_status_request} = 3'h0;
        {short_status_request, qualification_mode_cmd} = 2'h0;
        {cmd_absolute_level_setting, cmd_delta_level_setting, cmd_sample_delay_select} = 11'h000;
        {cmd_activation_delay_steps, cmd_full_duty_detect_enable} = 4'h0;
    end
    task automatic params(input logic [3:0] a, input logic [3:0] d, input logic [2:0] s,
                          input logic [2:0] f, input logic e, input logic nv);
        @(posedge sys_clk);
        {cmd_absolute_level_setting, cmd_delta_level_setting, cmd_sample_delay_select} <= {a, d, s};
        {cmd_activation_delay_steps, cmd_full_duty_detect_enable} <= {f, e};
        set_detection_params_cmd <= !nv;
        program_nonvolatile_cmd <= nv;
        @(posedge sys_clk);
        {set_detection_params_cmd, program_nonvolatile_cmd} <= 2'h0;
        // data is only valid with its strobe, so show garbage on levels and delay select afterwards
        {cmd_absolute_level_setting, cmd_delta_level_setting, cmd_sample_delay_select} <= ~{a, d, s};
    endtask
    // k: 0 full status, 1 short status, 2 qualification
    task automatic pulse(input int k);
        @(posedge sys_clk);
        full_status_request <= (k == 0);
        short_status_request <= (k == 1);
        qualification_mode_cmd <= (k == 2);
        @(posedge sys_clk);
        {full_status_request, short_status_request, qualification_mode_cmd} <= 3'h0;
    endtask
endmodule
`default_nettype wire

// ### dv/sdc_stall_ctrl_test.sv
// self-checking bench for the stall detection control block
`timescale 1ns/1ps
`default_nettype none
module sdc_stall_ctrl_test
    import sdc_pkg::*;
;
    logic sys_clk, rst, zero_cross_pin, ramp_active_pin, at_max_velocity_pin, full_step_pin;
    logic full_duty_pin, positioning, cmp_delta_low_pin, cmp_delta_high_pin, cmp_absolute_low_pin;
    logic switch_input_pin, set_detection_params_cmd, program_nonvolatile_cmd, cmd_full_duty_detect_enable;
    logic full_status_request, short_status_request, qualification_mode_cmd, nv_write_strobe;
    logic detection_enabled, sample_strobe, hard_stop, status_step_loss, status_stall, status_absolute_low;
    logic status_delta_low, status_delta_high, qualification_mode, switch_pin_analog_en, switch_state;
    logic [3:0] nv_absolute_level_setting, nv_delta_level_setting, cmd_absolute_level_setting;
    logic [3:0] cmd_delta_level_setting, nv_write_absolute, nv_write_delta;
    logic [3:0] absolute_level_setting, delta_level_setting;
    logic [2:0] cmd_sample_delay_select, cmd_activation_delay_steps;
    logic [15:0] internal_position, current_position;
    int err_total, tests_run;
    sdc_stall_ctrl uut (.*);
    sdc_master_model mst (.*);
    initial begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end
    task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_total++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge sys_clk);
    endtask
    task automatic fstep();
        full_step_pin <= 1'b1;
        step(3);
        full_step_pin <= 1'b0;
        step(3);
    endtask
    // one-cycle zero crossing pulse, then a wait bounded just past the expected delay
    task automatic zc(input int lim, output int n);
        @(posedge sys_clk);
        zero_cross_pin <= 1'b1;
        n = 0;
        while (sample_strobe !== 1'b1 && n < lim) begin
            @(posedge sys_clk);
            zero_cross_pin <= 1'b0;
            #1;
            n++;
        end
        if (n >= lim) begin
            err_total++;
            tally_and_finish();
        end
    endtask
    task automatic t_config();
        #1;
        check("abs_load", absolute_level_setting, 4'h3);
        check("det_en", detection_enabled, 1'b1);
        mst.params(4'h9, 4'h2, 3'h7, 3'h2, 1'b0, 1'b1);
        #1;
        check("nv_wr", {nv_write_strobe, nv_write_absolute, nv_write_delta}, 9'h192);
        check("abs_keep", absolute_level_setting, 4'h3);
        mst.params(4'h0, 4'h0, 3'h7, 3'h2, 1'b0, 1'b0);
        #1;
        check("det_off", detection_enabled, 1'b0);
        mst.params(4'h0, 4'hf, 3'h7, 3'h2, 1'b0, 1'b0);
        #1;
        check("del_only", {delta_level_setting, detection_enabled}, 5'h1f);
        mst.params(4'hf, 4'hf, 3'h7, 3'h2, 1'b0, 1'b0);
        #1;
        check("abs_max", absolute_level_setting, 4'hf);
    endtask
    task automatic t_unarmed();
        int n;
        @(posedge sys_clk);
        {positioning, cmp_absolute_low_pin, cmp_delta_low_pin} <= 3'h7;
        zc(SDC_DLY_CYC7 + 8, n);
        check("dly7", n >= SDC_DLY_CYC7 && n <= SDC_DLY_CYC7 + 5, 1'b1);
        step(3);
        check("unarmed", {status_stall, status_step_loss}, 2'h0);
    endtask
    task automatic t_stall();
        int n;
        logic hs;
        mst.params(4'hf, 4'hf, 3'h0, 3'h2, 1'b0, 1'b0);
        @(posedge sys_clk);
        {ramp_active_pin, at_max_velocity_pin} <= 2'h3;
        step(4);
        ramp_active_pin <= 1'b0;
        // let the ramp end settle so the first full step is counted
        step(3);
        fstep();
        zc(SDC_DLY_CYC0 + 8, n);
        step(3);
        check("early", status_stall, 1'b0);
        fstep();
        zc(SDC_DLY_CYC0 + 8, n);
        check("dly0", n >= SDC_DLY_CYC0 && n <= SDC_DLY_CYC0 + 5, 1'b1);
        hs = 1'b0;
        repeat (4) begin
            step(1);
            #1;
            hs = hs | hard_stop;
        end
        check("hard_stop", hs, 1'b1);
        check("flags", {status_step_loss, status_stall, status_absolute_low, status_delta_low, status_delta_high},
              5'h1e);
    endtask
    task automatic t_clear();
        int n;
        mst.pulse(1);
        #1;
        check("short", {status_step_loss, status_stall, status_absolute_low, status_delta_low}, 4'h7);
        @(posedge sys_clk);
        internal_position <= 16'h4321;
        mst.pulse(0);
        #1;
        check("full", {status_step_loss, status_stall, status_absolute_low, status_delta_low}, 4'h0);
        check("position", current_position, 16'h4321);
        @(posedge sys_clk);
        full_duty_pin <= 1'b1;
        zc(SDC_DLY_CYC0 + 8, n);
        step(3);
        check("full_duty", status_stall, 1'b0);
        mst.params(4'hf, 4'hf, 3'h0, 3'h2, 1'b1, 1'b0);
        zc(SDC_DLY_CYC0 + 8, n);
        step(3);
        check("full_duty_en", status_stall, 1'b1);
    endtask
    task automatic t_qual();
        switch_input_pin <= 1'b1;
        step(4);
        #1;
        check("switch", switch_state, 1'b1);
        mst.pulse(2);
        #1;
        check("qual", {qualification_mode, switch_pin_analog_en}, 2'h3);
        mst.pulse(0);
        switch_input_pin <= 1'b0;
        mst.params(4'h1, 4'h1, 3'h0, 3'h0, 1'b1, 1'b0);
        step(4);
        #1;
        check("stay", {qualification_mode, switch_state}, 2'h3);
    endtask
    initial begin
        err_total = 0;
        tests_run = 0;
        rst = 1'b1;
        {zero_cross_pin, ramp_active_pin, at_max_velocity_pin, full_step_pin, full_duty_pin} = 5'h00;
        {positioning, cmp_delta_low_pin, cmp_delta_high_pin, cmp_absolute_low_pin, switch_input_pin} = 5'h00;
        nv_absolute_level_setting = 4'h3;
        nv_delta_level_setting = 4'h0;
        internal_position = 16'h1234;
        step(4);
        rst <= 1'b0;
        step(2);
        t_config();
        t_unarmed();
        t_stall();
        t_clear();
        t_qual();
        tally_and_finish();
    end
endmodule
`default_nettype wire
